// ### design/osc_ctl.sv
// osc_ctl: crystal oscillator control, system clock selection and halt power modes
// assumes: crystal ticks, rc stable levels, halt and wake arrive synchronous to aclk;
// the clock tree downstream obeys the enables and source selects driven here
//
// Contract
// RULE1 - software picks drive strength by crystal frequency
// RULE2 - drive select locked while crystal pins running
// RULE3 - software sets drive select before enabling crystal
// RULE4 - fast crystal enable clears then sets stable
// RULE5 - bits 7..3 read zero, power-on zero
// RULE6 - speed-up bit picks fast start or low power
// RULE7 - speed-up bit frozen while slow crystal drives system
// RULE8 - slow crystal enable clears then sets stable
// RULE9 - select 111 switches system to sub clock
// RULE10 - sub clock source chosen, switch waits stable
// RULE11 - select 000..110 gives high clock divided
// RULE12 - software waits high stable after slow mode
// RULE13 - halt decodes keep bits into four modes
// RULE14 - sleep stops everything except watchdog
// RULE15 - sub-only idle stops high clock
// RULE16 - both-clock idle keeps both clocks
// RULE17 - high-only idle stops sub clock
// RULE18 - halt leaves registers and memory untouched
// RULE19 - halt sets power-down, clears timeout flag
// RULE20 - halt clears watchdog counter
// RULE21 - high source select picks rc or crystal
// RULE22 - stable flags from counted oscillator ticks
// RULE23 - clock handover gated, never glitching
module osc_ctl
  import osc_ctl_pkg::*;
#(
  parameter logic [15:0] STAB_TICKS = STAB_TICKS_DEF
)(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // oscillators
  input wire logic hs_xtal_tick,
  input wire logic ls_xtal_tick,
  input wire logic hs_rc_stable,
  input wire logic ls_rc_stable,
  input wire logic xtal_pin_fn_en,
  output logic hs_xtal_osc_en,
  output logic ls_xtal_osc_en,
  output logic hs_xtal_drive_sel,
  output logic ls_xtal_speedup,
  // cpu and watchdog
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic wdt_timeout,
  input wire logic clr_wdt_req,
  output logic wdt_clear,
  // clock tree
  output logic cpu_clk_en,
  output logic hs_clk_en,
  output logic sub_clk_en,
  output logic sys_clk_gate,
  output logic [2:0] sys_clk_div,
  output logic sys_src_sub,
  output logic hs_src_xtal,
  output logic sub_src_xtal
);

  st_s st_q;
  st_s st_d;

  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_wr;
  logic hit_w;
  logic hit_r;
  logic [7:0] rd_val;
  logic hs_tgt_ok;
  logic sub_tgt_ok;
  logic tgt_ok;
  logic cfg_diff;
  logic halted;
  logic hs_run;
  logic sub_run;
  logic ls_sys_xtal;

  assign aw_hs = awvalid && st_q.awready;
  assign w_hs = wvalid && st_q.wready;
  assign ar_hs = arvalid && st_q.arready;
  assign do_wr = st_q.aw_got && st_q.w_got && !st_q.bvalid;
  assign ls_sys_xtal = (st_q.sys_clk_sel == SEL_SUB) && st_q.low_freq_src_sel;

  always_comb
  begin
    hit_w = 1'b1;
    case (st_q.awaddr)
      OFS_SYS_CLK_CTRL, OFS_HS_CRYSTAL_CTRL, OFS_LS_CRYSTAL_CTRL, OFS_PWR_STATUS: hit_w = 1'b1;
      default: hit_w = 1'b0;
    endcase
  end

  // read mux; unimplemented bits read zero [RULE5]
  always_comb
  begin
    hit_r = 1'b1;
    rd_val = 8'h00;
    case (araddr)
      OFS_SYS_CLK_CTRL:
      begin
        rd_val[SCC_SEL_LSB +: 3] = st_q.sys_clk_sel;
        rd_val[SCC_HFS_BIT] = st_q.high_freq_src_sel;
        rd_val[SCC_LFS_BIT] = st_q.low_freq_src_sel;
        rd_val[SCC_HKEEP_BIT] = st_q.high_clk_keep_halt;
        rd_val[SCC_LKEEP_BIT] = st_q.low_clk_keep_halt;
      end
      OFS_HS_CRYSTAL_CTRL:
      begin
        rd_val[XC_OPT_BIT] = st_q.hs_xtal_drive_sel;
        rd_val[XC_STB_BIT] = st_q.hs_xtal_stable;
        rd_val[XC_EN_BIT] = st_q.hs_xtal_en;
      end
      OFS_LS_CRYSTAL_CTRL:
      begin
        rd_val[XC_OPT_BIT] = st_q.ls_xtal_speedup;
        rd_val[XC_STB_BIT] = st_q.ls_xtal_stable;
        rd_val[XC_EN_BIT] = st_q.ls_xtal_en;
      end
      OFS_PWR_STATUS:
      begin
        rd_val[PS_PDF_BIT] = st_q.power_down_flag;
        rd_val[PS_TO_BIT] = st_q.wdog_timeout_flag;
        rd_val[PS_MODE_LSB +: 3] = st_q.mode;
        rd_val[PS_SLOW_BIT] = (st_q.act_sel == SEL_SUB);
        rd_val[PS_PEND_BIT] = (st_q.ck != CK_RUN);
      end
      default: hit_r = 1'b0;
    endcase
  end

  // target of a pending switch: high source per select bit [RULE21], sub per select [RULE10]
  assign hs_tgt_ok = st_q.high_freq_src_sel ? st_q.hs_xtal_stable : hs_rc_stable;
  assign sub_tgt_ok = st_q.low_freq_src_sel ? st_q.ls_xtal_stable : ls_rc_stable;
  assign tgt_ok = (st_q.sys_clk_sel == SEL_SUB) ? sub_tgt_ok : hs_tgt_ok;
  assign cfg_diff = (st_q.sys_clk_sel != st_q.act_sel) ||
                    (st_q.high_freq_src_sel != st_q.act_hfs) ||
                    (st_q.low_freq_src_sel != st_q.act_lfs);

  // oscillator run per mode [RULE14] [RULE15] [RULE16] [RULE17]
  assign halted = (st_q.mode != MD_RUN);
  assign hs_run = !halted || st_q.mode == MD_IDLE_BOTH || st_q.mode == MD_IDLE_HIGH;
  assign sub_run = !halted || st_q.mode == MD_IDLE_BOTH || st_q.mode == MD_IDLE_SUB;

  always_comb
  begin
    st_d = st_q;
    st_d.wdt_clear = 1'b0;
    // write channels, taken in either order
    if (aw_hs)
    begin
      st_d.aw_got = 1'b1;
      st_d.awready = 1'b0;
      st_d.awaddr = awaddr;
    end
    if (w_hs)
    begin
      st_d.w_got = 1'b1;
      st_d.wready = 1'b0;
      st_d.wdata = wdata[7:0];
      st_d.wstrb0 = wstrb[0];
    end
    if (do_wr)
    begin
      st_d.bvalid = 1'b1;
      st_d.bresp = hit_w ? RESP_OKAY : RESP_SLVERR;
      if (hit_w && st_q.wstrb0)
      begin
        case (st_q.awaddr)
          OFS_SYS_CLK_CTRL:
          begin
            st_d.sys_clk_sel = st_q.wdata[SCC_SEL_LSB +: 3]; // [RULE9] [RULE11]
            st_d.high_freq_src_sel = st_q.wdata[SCC_HFS_BIT];
            st_d.low_freq_src_sel = st_q.wdata[SCC_LFS_BIT];
            st_d.high_clk_keep_halt = st_q.wdata[SCC_HKEEP_BIT];
            st_d.low_clk_keep_halt = st_q.wdata[SCC_LKEEP_BIT];
          end
          OFS_HS_CRYSTAL_CTRL:
          begin
            if (!(xtal_pin_fn_en && st_q.hs_xtal_en))
              st_d.hs_xtal_drive_sel = st_q.wdata[XC_OPT_BIT]; // [RULE2]
            st_d.hs_xtal_en = st_q.wdata[XC_EN_BIT];
          end
          OFS_LS_CRYSTAL_CTRL:
          begin
            if (!ls_sys_xtal)
              st_d.ls_xtal_speedup = st_q.wdata[XC_OPT_BIT]; // [RULE6] [RULE7]
            st_d.ls_xtal_en = st_q.wdata[XC_EN_BIT];
          end
          default:
          begin
          end
        endcase
      end
    end
    if (st_q.bvalid && bready)
    begin
      st_d.bvalid = 1'b0;
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
      st_d.awready = 1'b1;
      st_d.wready = 1'b1;
    end
    // read channel
    if (ar_hs)
    begin
      st_d.arready = 1'b0;
      st_d.rvalid = 1'b1;
      st_d.rdata = rd_val;
      st_d.rresp = hit_r ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_q.rvalid && rready)
    begin
      st_d.rvalid = 1'b0;
      st_d.arready = 1'b1;
    end

    // stabilisation: a stopped crystal restarts its count from zero [RULE4] [RULE8] [RULE22]
    st_d.hs_xtal_osc_en = st_d.hs_xtal_en && hs_run;
    st_d.ls_xtal_osc_en = st_d.ls_xtal_en && sub_run;
    if (!st_q.hs_xtal_osc_en)
    begin
      st_d.hs_cnt = 16'h0000;
      st_d.hs_xtal_stable = 1'b0;
    end
    else if (st_q.hs_cnt >= STAB_TICKS)
      st_d.hs_xtal_stable = 1'b1;
    else if (hs_xtal_tick)
      st_d.hs_cnt = st_q.hs_cnt + 16'h0001;
    if (!st_q.ls_xtal_osc_en)
    begin
      st_d.ls_cnt = 16'h0000;
      st_d.ls_xtal_stable = 1'b0;
    end
    else if (st_q.ls_cnt >= STAB_TICKS)
      st_d.ls_xtal_stable = 1'b1;
    else if (ls_xtal_tick)
      st_d.ls_cnt = st_q.ls_cnt + 16'h0001;

    // clock switch: wait for target, gate, hand over, ungate [RULE10] [RULE23]
    case (st_q.ck)
      CK_RUN:
        if (cfg_diff)
          st_d.ck = CK_WAIT;
      CK_WAIT:
        if (!cfg_diff)
          st_d.ck = CK_RUN;
        else if (tgt_ok)
        begin
          st_d.ck = CK_GAP;
          st_d.sys_gate = 1'b0;
          st_d.gap_cnt = 4'(GAP_CYC);
        end
      CK_GAP:
        if (st_q.gap_cnt == 4'h1)
        begin
          st_d.act_sel = st_q.sys_clk_sel;
          st_d.act_hfs = st_q.high_freq_src_sel;
          st_d.act_lfs = st_q.low_freq_src_sel;
          st_d.gap_cnt = 4'h0;
        end
        else if (st_q.gap_cnt == 4'h0)
        begin
          st_d.sys_gate = 1'b1;
          st_d.ck = CK_RUN;
        end
        else
          st_d.gap_cnt = st_q.gap_cnt - 4'h1;
      default: st_d.ck = CK_RUN;
    endcase

    // halt decode; only flags and mode change, registers keep their values [RULE13] [RULE18]
    if (!halted && halt_req)
    begin
      case ({st_q.high_clk_keep_halt, st_q.low_clk_keep_halt})
        2'b00: st_d.mode = MD_SLEEP;
        2'b01: st_d.mode = MD_IDLE_SUB;
        2'b11: st_d.mode = MD_IDLE_BOTH;
        default: st_d.mode = MD_IDLE_HIGH;
      endcase
      st_d.wdt_clear = 1'b1; // [RULE20]
    end
    else if (halted && wake_req)
      st_d.mode = MD_RUN;

    // flags: the halt event wins over a same-cycle clear [RULE19]
    if (clr_wdt_req)
      st_d.power_down_flag = 1'b0;
    if (wdt_timeout)
      st_d.wdog_timeout_flag = 1'b1;
    if (!halted && halt_req)
    begin
      st_d.power_down_flag = 1'b1;
      st_d.wdog_timeout_flag = 1'b0;
    end

    st_d.cpu_clk_en = (st_d.mode == MD_RUN);
    st_d.hs_clk_en = (st_d.mode == MD_RUN) || st_d.mode == MD_IDLE_BOTH ||
                     st_d.mode == MD_IDLE_HIGH;
    st_d.sub_clk_en = (st_d.mode == MD_RUN) || st_d.mode == MD_IDLE_BOTH ||
                      st_d.mode == MD_IDLE_SUB;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= '0;
      st_q.awready <= 1'b1;
      st_q.wready <= 1'b1;
      st_q.arready <= 1'b1;
      st_q.sys_gate <= 1'b1;
      st_q.cpu_clk_en <= 1'b1;
      st_q.hs_clk_en <= 1'b1;
      st_q.sub_clk_en <= 1'b1;
      st_q.mode <= MD_RUN;
      st_q.ck <= CK_RUN;
    end
    else if (ce)
      st_q <= st_d;
  end

  assign awready = st_q.awready;
  assign wready = st_q.wready;
  assign bvalid = st_q.bvalid;
  assign bresp = st_q.bresp;
  assign arready = st_q.arready;
  assign rvalid = st_q.rvalid;
  assign rdata = {24'h000000, st_q.rdata};
  assign rresp = st_q.rresp;
  assign hs_xtal_osc_en = st_q.hs_xtal_osc_en;
  assign ls_xtal_osc_en = st_q.ls_xtal_osc_en;
  assign hs_xtal_drive_sel = st_q.hs_xtal_drive_sel;
  assign ls_xtal_speedup = st_q.ls_xtal_speedup;
  assign wdt_clear = st_q.wdt_clear;
  assign cpu_clk_en = st_q.cpu_clk_en;
  assign hs_clk_en = st_q.hs_clk_en;
  assign sub_clk_en = st_q.sub_clk_en;
  assign sys_clk_gate = st_q.sys_gate;
  assign sys_clk_div = st_q.act_sel;
  assign sys_src_sub = (st_q.act_sel == SEL_SUB);
  assign hs_src_xtal = st_q.act_hfs;
  assign sub_src_xtal = st_q.act_lfs;

  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  wire power_down_flag_set = st_q.power_down_flag && !st_q.wdog_timeout_flag;

  sequence s_halt_taken;
    ce && !halted && halt_req;
  endsequence

  sequence s_gate_low;
    !sys_clk_gate;
  endsequence

  chk_drive_sel_lock: assert property ( // [RULE2]
    (ce && xtal_pin_fn_en && st_q.hs_xtal_en) |=> $stable(hs_xtal_drive_sel))
    else $error("drive select changed while crystal running");
  chk_speedup_lock: assert property ( // [RULE7]
    (ce && ls_sys_xtal) |=> $stable(ls_xtal_speedup))
    else $error("speed-up changed while slow crystal is system clock");
  chk_hs_stable_clear: assert property ( // [RULE4]
    (ce && !st_q.hs_xtal_osc_en) |=> ce |=> !st_q.hs_xtal_stable)
    else $error("fast crystal stable flag not cleared");
  chk_ls_stable_clear: assert property ( // [RULE8]
    (ce && !st_q.ls_xtal_osc_en) |=> ce |=> !st_q.ls_xtal_stable)
    else $error("slow crystal stable flag not cleared");
  chk_stable_count: assert property ( // [RULE22]
    $rose(st_q.hs_xtal_stable) |-> st_q.hs_cnt >= STAB_TICKS)
    else $error("stable flag set before count done");
  chk_halt_flags: assert property ( // [RULE19]
    s_halt_taken |=> power_down_flag_set)
    else $error("halt did not set power-down or clear timeout");
  chk_halt_wdt: assert property ( // [RULE20]
    s_halt_taken |=> wdt_clear ##1 !wdt_clear)
    else $error("watchdog clear not one pulse on halt");
  chk_halt_decode: assert property ( // [RULE13]
    s_halt_taken |=> (st_q.mode == MD_SLEEP) == (!$past(st_q.high_clk_keep_halt) &&
                     !$past(st_q.low_clk_keep_halt)))
    else $error("halt mode decode wrong");
  chk_sleep_clocks: assert property ( // [RULE14]
    (st_q.mode == MD_SLEEP) |-> !cpu_clk_en && !hs_clk_en && !sub_clk_en)
    else $error("clock running in sleep");
  chk_idle_high: assert property ( // [RULE17]
    (st_q.mode == MD_IDLE_HIGH) |-> hs_clk_en && !sub_clk_en && !cpu_clk_en)
    else $error("high-only idle clocks wrong");
  chk_idle_sub: assert property ( // [RULE15]
    (st_q.mode == MD_IDLE_SUB) |-> !hs_clk_en && sub_clk_en)
    else $error("sub-only idle clocks wrong");
  chk_switch_gated: assert property ( // [RULE23]
    $changed(sys_clk_div) |-> !$past(sys_clk_gate) ##0 s_gate_low)
    else $error("source changed while clock ungated");
  chk_switch_stable: assert property ( // [RULE10]
    (ce && st_q.ck == CK_WAIT && !tgt_ok) |=> st_q.ck != CK_GAP)
    else $error("switch began before target stable");

endmodule // osc_ctl

// ### inc/osc_ctl_pkg.sv
// osc_ctl_pkg: register map, field positions, state types and timing for osc_ctl
// assumes: one 40 MHz bus clock, AXI4-Lite register access with 32-bit data
package osc_ctl_pkg;

  // timing
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned GAP_NS = 50;
  localparam int unsigned GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [15:0] STAB_TICKS_DEF = 16'h0400;

  // register byte offsets
  localparam logic [7:0] OFS_SYS_CLK_CTRL = 8'h00;
  localparam logic [7:0] OFS_HS_CRYSTAL_CTRL = 8'h08;
  localparam logic [7:0] OFS_LS_CRYSTAL_CTRL = 8'h0C;
  localparam logic [7:0] OFS_PWR_STATUS = 8'h10;

  // sys_clk_ctrl fields
  localparam int unsigned SCC_SEL_LSB = 5;
  localparam int unsigned SCC_HFS_BIT = 3;
  localparam int unsigned SCC_LFS_BIT = 2;
  localparam int unsigned SCC_HKEEP_BIT = 1;
  localparam int unsigned SCC_LKEEP_BIT = 0;
  localparam logic [2:0] SEL_SUB = 3'h7;

  // crystal control fields, shared by both crystal registers
  localparam int unsigned XC_OPT_BIT = 2;
  localparam int unsigned XC_STB_BIT = 1;
  localparam int unsigned XC_EN_BIT = 0;

  // pwr_status fields
  localparam int unsigned PS_PDF_BIT = 0;
  localparam int unsigned PS_TO_BIT = 1;
  localparam int unsigned PS_MODE_LSB = 2;
  localparam int unsigned PS_SLOW_BIT = 5;
  localparam int unsigned PS_PEND_BIT = 6;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MD_RUN = 3'b000,
    MD_SLEEP = 3'b001,
    MD_IDLE_SUB = 3'b010,
    MD_IDLE_BOTH = 3'b011,
    MD_IDLE_HIGH = 3'b100
  } mode_e;

  typedef enum logic [1:0] {
    CK_RUN = 2'b00,
    CK_WAIT = 2'b01,
    CK_GAP = 2'b10
  } ck_e;

  typedef struct packed {
    // bus
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    // software registers
    logic [2:0] sys_clk_sel;
    logic high_freq_src_sel;
    logic low_freq_src_sel;
    logic high_clk_keep_halt;
    logic low_clk_keep_halt;
    logic hs_xtal_drive_sel;
    logic hs_xtal_en;
    logic ls_xtal_speedup;
    logic ls_xtal_en;
    // stabilisation
    logic [15:0] hs_cnt;
    logic [15:0] ls_cnt;
    logic hs_xtal_stable;
    logic ls_xtal_stable;
    // power mode
    mode_e mode;
    logic power_down_flag;
    logic wdog_timeout_flag;
    logic wdt_clear;
    // clock switch
    ck_e ck;
    logic [3:0] gap_cnt;
    logic [2:0] act_sel;
    logic act_hfs;
    logic act_lfs;
    logic sys_gate;
    // clock enables
    logic cpu_clk_en;
    logic hs_clk_en;
    logic sub_clk_en;
    logic hs_xtal_osc_en;
    logic ls_xtal_osc_en;
  } st_s;

endpackage

// ### tb/tb_osc_ctl.sv
// tb_osc_ctl: self-checking bench for osc_ctl over its axi4-lite registers and pins
// assumes: osc_ctl_pkg compiled first; short stabilisation count set on the instance
module tb_osc_ctl
  import osc_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, hs_tick, ls_tick, hs_rc_ok, pin_fn, halt_req, wake_req, wdt_to;
  logic clr_wdt, wdt_clear, cpu_clk_en, hs_clk_en, sub_clk_en, sys_clk_gate, sys_src_sub;
  logic hs_src_xtal, hs_xtal_osc_en, hs_xtal_drive_sel, ls_xtal_speedup;
  logic ls_rc_ok, ls_xtal_osc_en, sub_src_xtal;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [2:0] sys_clk_div;
  int err_count, num_checks, cyc;

  osc_ctl #(.STAB_TICKS(16'h0004)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .hs_xtal_tick(hs_tick), .ls_xtal_tick(ls_tick), .hs_rc_stable(hs_rc_ok),
    .ls_rc_stable(ls_rc_ok), .xtal_pin_fn_en(pin_fn), .hs_xtal_osc_en(hs_xtal_osc_en),
    .ls_xtal_osc_en(ls_xtal_osc_en), .hs_xtal_drive_sel(hs_xtal_drive_sel),
    .ls_xtal_speedup(ls_xtal_speedup), .halt_req(halt_req), .wake_req(wake_req),
    .wdt_timeout(wdt_to), .clr_wdt_req(clr_wdt), .wdt_clear(wdt_clear),
    .cpu_clk_en(cpu_clk_en), .hs_clk_en(hs_clk_en), .sub_clk_en(sub_clk_en),
    .sys_clk_gate(sys_clk_gate), .sys_clk_div(sys_clk_div), .sys_src_sub(sys_src_sub),
    .hs_src_xtal(hs_src_xtal), .sub_src_xtal(sub_src_xtal)
  );

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one write; address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
        break;
    end
    check({31'h0, bvalid}, 32'h1);
    check({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    d = 32'hFFFFFFFF;
    r = 2'h3;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        r = rresp;
        break;
      end
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(d, e);
    check({30'h0, r}, {30'h0, er});
  endtask

  task automatic wait_stable(input logic [7:0] a);
    int n;
    logic [31:0] d;
    logic [1:0] r;
    for (n = 0; n < 40; n++)
    begin
      rd(a, d, r);
      if (d[XC_STB_BIT] === 1'b1)
        break;
    end
  endtask

  // waits for a handover, which must pass through a gated interval
  task automatic wait_sw(input logic [2:0] dv, input logic sb, input logic hx);
    int n;
    logic low;
    low = 1'b0;
    for (n = 0; n < 200; n++)
    begin
      @(posedge aclk);
      if (sys_clk_gate === 1'b0)
        low = 1'b1;
      if (sys_clk_div === dv && sys_src_sub === sb && hs_src_xtal === hx
          && sys_clk_gate === 1'b1 && low)
        break;
    end
    check({31'h0, low}, 32'h1);
    check({29'h0, sys_clk_div}, {29'h0, dv});
    check({31'h0, sys_src_sub}, {31'h0, sb});
    check({31'h0, hs_src_xtal}, {31'h0, hx});
  endtask

  task automatic t_reset;
    rchk(OFS_SYS_CLK_CTRL, 32'h0, RESP_OKAY);
    rchk(OFS_HS_CRYSTAL_CTRL, 32'h0, RESP_OKAY);
    rchk(OFS_LS_CRYSTAL_CTRL, 32'h0, RESP_OKAY);
    rchk(8'h04, 32'h0, RESP_SLVERR);
    wr(8'h04, 8'hFF, RESP_SLVERR);
  endtask

  task automatic t_hs;
    pin_fn <= 1'b1;
    wr(OFS_HS_CRYSTAL_CTRL, 8'h04, RESP_OKAY);
    wr(OFS_HS_CRYSTAL_CTRL, 8'hFD, RESP_OKAY);
    rchk(OFS_HS_CRYSTAL_CTRL, 32'h05, RESP_OKAY);
    check({31'h0, hs_xtal_osc_en}, 32'h1);
    hs_tick <= 1'b1;
    wait_stable(OFS_HS_CRYSTAL_CTRL);
    rchk(OFS_HS_CRYSTAL_CTRL, 32'h07, RESP_OKAY);
    wr(OFS_HS_CRYSTAL_CTRL, 8'h01, RESP_OKAY);
    rchk(OFS_HS_CRYSTAL_CTRL, 32'h07, RESP_OKAY);
    check({31'h0, hs_xtal_drive_sel}, 32'h1);
    pin_fn <= 1'b0;
    wr(OFS_HS_CRYSTAL_CTRL, 8'h01, RESP_OKAY);
    rchk(OFS_HS_CRYSTAL_CTRL, 32'h03, RESP_OKAY);
    check({31'h0, hs_xtal_drive_sel}, 32'h0);
    hs_tick <= 1'b0;
    wr(OFS_HS_CRYSTAL_CTRL, 8'h00, RESP_OKAY);
    wr(OFS_HS_CRYSTAL_CTRL, 8'h01, RESP_OKAY);
    rchk(OFS_HS_CRYSTAL_CTRL, 32'h01, RESP_OKAY);
    hs_tick <= 1'b1;
    wait_stable(OFS_HS_CRYSTAL_CTRL);
    wr(OFS_SYS_CLK_CTRL, 8'h08, RESP_OKAY);
    wait_sw(3'h0, 1'b0, 1'b1);
  endtask

  task automatic t_ls;
    int n;
    wr(OFS_LS_CRYSTAL_CTRL, 8'h01, RESP_OKAY);
    rchk(OFS_LS_CRYSTAL_CTRL, 32'h01, RESP_OKAY);
    check({31'h0, ls_xtal_osc_en}, 32'h1);
    wr(OFS_SYS_CLK_CTRL, 8'hE4, RESP_OKAY);
    rchk(OFS_PWR_STATUS, 32'h40, RESP_OKAY);
    check({31'h0, sys_src_sub}, 32'h0);
    ls_tick <= 1'b1;
    wait_sw(SEL_SUB, 1'b1, 1'b0);
    check({31'h0, sub_src_xtal}, 32'h1);
    rchk(OFS_LS_CRYSTAL_CTRL, 32'h03, RESP_OKAY);
    wr(OFS_LS_CRYSTAL_CTRL, 8'h05, RESP_OKAY);
    rchk(OFS_LS_CRYSTAL_CTRL, 32'h03, RESP_OKAY);
    check({31'h0, ls_xtal_speedup}, 32'h0);
    hs_rc_ok <= 1'b0;
    wr(OFS_SYS_CLK_CTRL, 8'hC0, RESP_OKAY);
    check({31'h0, sys_src_sub}, 32'h1);
    hs_rc_ok <= 1'b1;
    wait_sw(3'h6, 1'b0, 1'b0);
    for (n = 5; n >= 0; n--)
    begin
      wr(OFS_SYS_CLK_CTRL, {n[2:0], 5'h00}, RESP_OKAY);
      wait_sw(n[2:0], 1'b0, 1'b0);
    end
    wr(OFS_LS_CRYSTAL_CTRL, 8'h05, RESP_OKAY);
    rchk(OFS_LS_CRYSTAL_CTRL, 32'h07, RESP_OKAY);
    check({31'h0, ls_xtal_speedup}, 32'h1);
    ls_rc_ok <= 1'b0;
    wr(OFS_SYS_CLK_CTRL, 8'hE0, RESP_OKAY);
    rchk(OFS_PWR_STATUS, 32'h40, RESP_OKAY);
    ls_rc_ok <= 1'b1;
    wait_sw(SEL_SUB, 1'b1, 1'b0);
    check({31'h0, sub_src_xtal}, 32'h0);
    wr(OFS_SYS_CLK_CTRL, 8'h00, RESP_OKAY);
    wait_sw(3'h0, 1'b0, 1'b0);
  endtask

  task automatic t_halt;
    logic [1:0] kb [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
    logic [2:0] md [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
    logic [2:0] en [4] = '{3'b000, 3'b001, 3'b011, 3'b010};
    int k;
    for (k = 0; k < 4; k++)
    begin
      wr(OFS_SYS_CLK_CTRL, {6'h00, kb[k]}, RESP_OKAY);
      wdt_to <= 1'b1;
      @(posedge aclk);
      wdt_to <= 1'b0;
      @(posedge aclk);
      rchk(OFS_PWR_STATUS, 32'h02, RESP_OKAY);
      halt_req <= 1'b1;
      @(posedge aclk);
      halt_req <= 1'b0;
      @(posedge aclk);
      check({31'h0, wdt_clear}, 32'h1);
      check({29'h0, cpu_clk_en, hs_clk_en, sub_clk_en}, {29'h0, en[k]});
      check({29'h0, cpu_clk_en, hs_clk_en, sub_clk_en}, {29'h0, en[k]});
      rchk(OFS_PWR_STATUS, {27'h0, md[k], 2'b01}, RESP_OKAY);
      rchk(OFS_SYS_CLK_CTRL, {30'h0, kb[k]}, RESP_OKAY);
      wake_req <= 1'b1;
      @(posedge aclk);
      wake_req <= 1'b0;
      clr_wdt <= 1'b1;
      @(posedge aclk);
      clr_wdt <= 1'b0;
      @(posedge aclk);
      check({31'h0, cpu_clk_en}, 32'h1);
      rchk(OFS_PWR_STATUS, 32'h00, RESP_OKAY);
    end
  endtask

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {hs_tick, ls_tick, pin_fn, halt_req, wake_req, wdt_to, clr_wdt} = '0;
    hs_rc_ok = 1'b1;
    ls_rc_ok = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_hs();
    t_ls();
    t_halt();
    print_verdict();
  end
endmodule // tb_osc_ctl
